/* rtl/jlpo_cfg.svh */
// Constants of the link parameter override register bank
//
// Function
// - Gates register bit 0 gates writes to octets-per-frame; while clear the default holds.
// - Gates register bit 1 gates writes to the five-bit frames-per-multiframe field.
// - Scrambling register bit 7 enables scrambling just as the scrambling pin does.
// - Octets-per-frame is count minus one, resets to 1 (two octets, one lane); 0 is two lanes.
// - Default frames-per-multiframe minus one is 16 at one octet per frame and 8 at two.
// - With its gate set, the stored five-bit field is frames per multiframe minus one.
// - Driver current code resets to 0 (16 mA); bit 3 adds 16, bits 2, 1, 0 take 8, 4, 2 mA.
// - Lane-one force, bit 3, puts the lane-one forced word on the upper lane.
// - Lane-one word: bits 7:0 of one register and 7:6 of the next, used only while forced.
// - Lane-two force, bit 6, puts the lane-two forced word on the lower lane.
// - Lane-two word: bits 7:4 of one register and 7:2 of the next, used only while forced.
// - Detect bit 0 sends a four-bit low-latency copy of the sample code to detect.
// - Detect bit 5, with bit 0 clear, sends a four-bit averaged power estimate, about 1 dB per step.
// - Detect bits 4:2 set the averaging length between 1K and 16K samples.
// - When enabled, lane alignment follows code group sync in one-lane and two-lane modes.
`ifndef JLPO_CFG_SVH
`define JLPO_CFG_SVH

`define JLPO_ADDR_LINK_CTRL   8'hA0
`define JLPO_ADDR_GATES       8'hA1
`define JLPO_ADDR_SCRAMBLE    8'hA5
`define JLPO_ADDR_OCTETS      8'hA6
`define JLPO_ADDR_FRAMES      8'hA7
`define JLPO_ADDR_DRIVER      8'hB0
`define JLPO_ADDR_FORCE       8'hB4
`define JLPO_ADDR_L1_WORD_A   8'hB6
`define JLPO_ADDR_L1_WORD_B   8'hB7
`define JLPO_ADDR_L2_WORD_A   8'hB8
`define JLPO_ADDR_L2_WORD_B   8'hB9
`define JLPO_ADDR_DETECT      8'hD6

`define JLPO_BIT_ALIGN_EN     0
`define JLPO_BIT_GATE_F       0
`define JLPO_BIT_GATE_K       1
`define JLPO_BIT_SCRAMBLE     7
`define JLPO_BIT_FORCE_L1     3
`define JLPO_BIT_FORCE_L2     6
`define JLPO_BIT_FAST_DET     0
`define JLPO_BIT_PWR_DET      5
`define JLPO_LEN_LSB          2
`define JLPO_LEN_MSB          4

`define JLPO_RST_OCTETS       8'h01
`define JLPO_RST_FRAMES       5'h08
`define JLPO_K_DEF_10X        5'h10
`define JLPO_K_DEF_20X        5'h08
`define JLPO_CUR_BASE_MA      6'h10
`define JLPO_CUR_B3_MA        6'h10
`define JLPO_CUR_B2_MA        6'h08
`define JLPO_CUR_B1_MA        6'h04
`define JLPO_CUR_B0_MA        6'h02
`define JLPO_ILAS_MF          7'h04
`define JLPO_AVG_BASE_LOG2    10
`define JLPO_AVG_MAX_CODE     3'h4

`endif

/* rtl/jlpo_pkg.sv */
// Types shared by the link parameter override register bank
package jlpo_pkg;

  typedef enum logic [1:0] {
    JLPO_DET_OFF,
    JLPO_DET_FAST,
    JLPO_DET_POWER
  } jlpo_det_src_t;

  typedef enum logic [1:0] {
    JLPO_LNK_CGS,
    JLPO_LNK_ILAS,
    JLPO_LNK_DATA
  } jlpo_lnk_state_t;

endpackage : jlpo_pkg

/* rtl/jlpo_pwr_est.sv */
// Averaged input power estimate on a four-bit scale of about 1 dB per step
`timescale 1ns/1ps
`include "jlpo_cfg.svh"

module jlpo_pwr_est #(
  parameter int SAMPLE_W = 14
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  input  wire logic                enable_in,
  input  wire logic                sample_valid_in,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic [2:0]          len_code_in,
  output logic      [3:0]          level_out
);

  localparam int MAG_W = SAMPLE_W - 1;
  localparam int PWR_W = 2 * MAG_W;
  localparam int ACC_W = PWR_W + `JLPO_AVG_BASE_LOG2 + 4;
  localparam int CNT_W = `JLPO_AVG_BASE_LOG2 + 4;

  // Power to dB below full scale: 3 dB per octave plus a two-step fraction
  function automatic logic [3:0] jlpo_pwr_to_level(input logic [PWR_W-1:0] p);
    int idx;
    int down;
    idx  = -1;
    down = 0;
    for (int i = 0; i < PWR_W; i++) begin
      if (p[i]) begin
        idx = i;
      end
    end
    if (idx < 0) begin
      return 4'h0;
    end
    down = 3 * (PWR_W - 1 - idx);
    if (idx >= 2 && p[idx-1] && p[idx-2]) begin
      down = down - 2;
    end else if (idx >= 1 && p[idx-1]) begin
      down = down - 1;
    end
    if (down < 0) begin
      down = 0;
    end
    return (down >= 15) ? 4'h0 : 4'(15 - down);
  endfunction

  logic [2:0]          code_sat;
  logic [CNT_W-1:0]    last_cnt;
  logic [MAG_W-1:0]    mag;
  logic [ACC_W-1:0]    acc_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [ACC_W-1:0]    mean;

  assign code_sat = (len_code_in > `JLPO_AVG_MAX_CODE) ? `JLPO_AVG_MAX_CODE : len_code_in;
  assign last_cnt = CNT_W'((32'h1 << (`JLPO_AVG_BASE_LOG2 + code_sat)) - 1);
  // Ones complement magnitude avoids overflow on the most negative code
  assign mag      = sample_in[SAMPLE_W-1] ? ~sample_in[MAG_W-1:0] : sample_in[MAG_W-1:0];
  assign mean     = acc_q >> (`JLPO_AVG_BASE_LOG2 + code_sat);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_q     <= '0;
      cnt_q     <= '0;
      level_out <= 4'h0;
    end else if (!enable_in) begin
      acc_q <= '0;
      cnt_q <= '0;
    end else if (sample_valid_in) begin
      if (cnt_q >= last_cnt) begin
        level_out <= jlpo_pwr_to_level(PWR_W'(mean));
        acc_q     <= ACC_W'(mag * mag);
        cnt_q     <= '0;
      end else begin
        acc_q <= acc_q + ACC_W'(mag * mag);
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

endmodule // jlpo_pwr_est

/* rtl/jlpo_regs.sv */
// Link parameter override register bank of the serial converter transmitter
`timescale 1ns/1ps
`include "jlpo_cfg.svh"

module jlpo_regs #(
  parameter int SAMPLE_W = 14,
  parameter int LANE_W   = 10
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  // Register port
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic [7:0]          reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [7:0]          reg_rdata_out,
  // Pins and core side
  input  wire logic                scramble_pin_in,
  input  wire logic                sync_req_n_in,
  input  wire logic                frame_tick_in,
  input  wire logic [LANE_W-1:0]   coder_lane1_in,
  input  wire logic [LANE_W-1:0]   coder_lane2_in,
  input  wire logic                sample_valid_in,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  // Configuration to the transmitter
  output logic      [7:0]          octets_per_frame_out,
  output logic      [4:0]          frames_per_mf_out,
  output logic                     dual_lane_out,
  output logic                     scramble_enable_out,
  output logic      [3:0]          driver_current_code_out,
  output logic      [5:0]          driver_current_ma_out,
  output logic      [LANE_W-1:0]   lane1_out,
  output logic      [LANE_W-1:0]   lane2_out,
  output logic      [1:0]          link_phase_out,
  output logic                     ilas_active_out,
  output logic      [3:0]          detect_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [5:0] jlpo_current_ma(input logic [3:0] code);
    logic [5:0] ma;
    ma = `JLPO_CUR_BASE_MA;
    if (code[3]) begin
      ma = ma + `JLPO_CUR_B3_MA;
    end
    if (code[2]) begin
      ma = ma - `JLPO_CUR_B2_MA;
    end
    if (code[1]) begin
      ma = ma - `JLPO_CUR_B1_MA;
    end
    if (code[0]) begin
      ma = ma - `JLPO_CUR_B0_MA;
    end
    return ma;
  endfunction

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic                      align_en_q;
  logic                      gate_f_q;
  logic                      gate_k_q;
  logic                      soft_scramble_enable_q;
  logic [7:0]                octets_q;
  logic [4:0]                frames_q;
  logic [3:0]                driver_current_code_q;
  logic                      lane_one_force_q;
  logic                      lane_two_force_q;
  logic [7:0]                l1_word_a_q;
  logic [1:0]                l1_word_b_q;
  logic [3:0]                l2_word_a_q;
  logic [5:0]                l2_word_b_q;
  logic                      fast_code_detect_enable_q;
  logic                      power_estimate_enable_q;
  logic [2:0]                power_average_length_q;

  logic                      wr_link;
  logic                      wr_gates;
  logic                      wr_scr;
  logic                      wr_oct;
  logic                      wr_frm;
  logic                      wr_drv;
  logic                      wr_frc;
  logic                      wr_l1a;
  logic                      wr_l1b;
  logic                      wr_l2a;
  logic                      wr_l2b;
  logic                      wr_det;

  assign wr_link  = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_LINK_CTRL);
  assign wr_gates = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_GATES);
  assign wr_scr   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_SCRAMBLE);
  assign wr_oct   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_OCTETS);
  assign wr_frm   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_FRAMES);
  assign wr_drv   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_DRIVER);
  assign wr_frc   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_FORCE);
  assign wr_l1a   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_L1_WORD_A);
  assign wr_l1b   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_L1_WORD_B);
  assign wr_l2a   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_L2_WORD_A);
  assign wr_l2b   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_L2_WORD_B);
  assign wr_det   = reg_wr_in && wr_hit(reg_addr_in, `JLPO_ADDR_DETECT);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      align_en_q <= 1'b0;
      gate_f_q   <= 1'b0;
      gate_k_q   <= 1'b0;
    end else begin
      if (wr_link) begin
        align_en_q <= reg_wdata_in[`JLPO_BIT_ALIGN_EN];
      end
      if (wr_gates) begin
        gate_f_q <= reg_wdata_in[`JLPO_BIT_GATE_F];
        gate_k_q <= reg_wdata_in[`JLPO_BIT_GATE_K];
      end
    end
  end

  // Frame length writes are dropped, not deferred, while the gate is clear
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      octets_q <= `JLPO_RST_OCTETS;
    end else if (wr_oct && gate_f_q) begin
      octets_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frames_q <= `JLPO_RST_FRAMES;
    end else if (wr_frm && gate_k_q) begin
      frames_q <= reg_wdata_in[4:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_scramble_enable_q <= 1'b0;
      driver_current_code_q  <= 4'h0;
    end else begin
      if (wr_scr) begin
        soft_scramble_enable_q <= reg_wdata_in[`JLPO_BIT_SCRAMBLE];
      end
      if (wr_drv) begin
        driver_current_code_q <= reg_wdata_in[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lane_one_force_q <= 1'b0;
      lane_two_force_q <= 1'b0;
      l1_word_a_q      <= 8'h00;
      l1_word_b_q      <= 2'h0;
      l2_word_a_q      <= 4'h0;
      l2_word_b_q      <= 6'h00;
    end else begin
      if (wr_frc) begin
        lane_one_force_q <= reg_wdata_in[`JLPO_BIT_FORCE_L1];
        lane_two_force_q <= reg_wdata_in[`JLPO_BIT_FORCE_L2];
      end
      if (wr_l1a) begin
        l1_word_a_q <= reg_wdata_in;
      end
      if (wr_l1b) begin
        l1_word_b_q <= reg_wdata_in[7:6];
      end
      if (wr_l2a) begin
        l2_word_a_q <= reg_wdata_in[7:4];
      end
      if (wr_l2b) begin
        l2_word_b_q <= reg_wdata_in[7:2];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fast_code_detect_enable_q <= 1'b0;
      power_estimate_enable_q   <= 1'b0;
      power_average_length_q    <= 3'h0;
    end else if (wr_det) begin
      fast_code_detect_enable_q <= reg_wdata_in[`JLPO_BIT_FAST_DET];
      power_estimate_enable_q   <= reg_wdata_in[`JLPO_BIT_PWR_DET];
      power_average_length_q    <= reg_wdata_in[`JLPO_LEN_MSB:`JLPO_LEN_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective link parameters

  logic [7:0]            eff_octets;
  logic [4:0]            eff_frames;
  logic [LANE_W-1:0]     lane_one_forced_word;
  logic [LANE_W-1:0]     lane_two_forced_word;

  // Without its gate a field ignores what was stored: octets keep the reset value, frames take the default for the octet count
  assign eff_octets = gate_f_q ? octets_q : `JLPO_RST_OCTETS;
  assign eff_frames = gate_k_q ? frames_q :
                      (eff_octets == 8'h00) ? `JLPO_K_DEF_10X : `JLPO_K_DEF_20X;
  assign lane_one_forced_word = {l1_word_a_q, l1_word_b_q};
  assign lane_two_forced_word = {l2_word_a_q, l2_word_b_q};

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      octets_per_frame_out    <= `JLPO_RST_OCTETS;
      frames_per_mf_out       <= `JLPO_K_DEF_20X;
      dual_lane_out           <= 1'b0;
      scramble_enable_out     <= 1'b0;
      driver_current_code_out <= 4'h0;
      driver_current_ma_out   <= `JLPO_CUR_BASE_MA;
    end else begin
      octets_per_frame_out    <= eff_octets;
      frames_per_mf_out       <= eff_frames;
      dual_lane_out           <= (eff_octets == 8'h00);
      scramble_enable_out     <= soft_scramble_enable_q | scramble_pin_in;
      driver_current_code_out <= driver_current_code_q;
      driver_current_ma_out   <= jlpo_current_ma(driver_current_code_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane word substitution

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lane1_out <= '0;
      lane2_out <= '0;
    end else begin
      lane1_out <= lane_one_force_q ? lane_one_forced_word : coder_lane1_in;
      lane2_out <= lane_two_force_q ? lane_two_forced_word : coder_lane2_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link phase: code group sync, optional alignment sequence, data

  jlpo_pkg::jlpo_lnk_state_t lnk_state_q;
  logic [6:0]                ilas_left_q;
  logic [6:0]                ilas_frames;

  // Four multiframes of alignment, counted in frames
  assign ilas_frames = 7'(`JLPO_ILAS_MF * ({2'h0, eff_frames} + 7'h01) - 7'h01);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk_state_q <= jlpo_pkg::JLPO_LNK_CGS;
      ilas_left_q <= 7'h00;
    end else if (!sync_req_n_in) begin
      lnk_state_q <= jlpo_pkg::JLPO_LNK_CGS;
      ilas_left_q <= 7'h00;
    end else begin
      case (lnk_state_q)
        jlpo_pkg::JLPO_LNK_CGS: begin
          if (align_en_q) begin
            lnk_state_q <= jlpo_pkg::JLPO_LNK_ILAS;
            ilas_left_q <= ilas_frames;
          end else begin
            lnk_state_q <= jlpo_pkg::JLPO_LNK_DATA;
          end
        end
        jlpo_pkg::JLPO_LNK_ILAS: begin
          if (frame_tick_in) begin
            if (ilas_left_q == 7'h00) begin
              lnk_state_q <= jlpo_pkg::JLPO_LNK_DATA;
            end else begin
              ilas_left_q <= ilas_left_q - 7'h01;
            end
          end
        end
        jlpo_pkg::JLPO_LNK_DATA: begin
          lnk_state_q <= jlpo_pkg::JLPO_LNK_DATA;
        end
        default: begin
          lnk_state_q <= jlpo_pkg::JLPO_LNK_CGS;
        end
      endcase
    end
  end

  assign link_phase_out  = lnk_state_q;
  assign ilas_active_out = (lnk_state_q == jlpo_pkg::JLPO_LNK_ILAS);

  ////////////////////////////////////////////////////////////////////////////
  // Detect output

  jlpo_pkg::jlpo_det_src_t det_src;
  logic [3:0]              pwr_level;
  logic [3:0]              fast_code_q;

  // Fast code wins when both are set: it is the one meant for low latency
  always_comb begin
    if (fast_code_detect_enable_q) begin
      det_src = jlpo_pkg::JLPO_DET_FAST;
    end else if (power_estimate_enable_q) begin
      det_src = jlpo_pkg::JLPO_DET_POWER;
    end else begin
      det_src = jlpo_pkg::JLPO_DET_OFF;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fast_code_q <= 4'h0;
    end else if (sample_valid_in) begin
      fast_code_q <= sample_in[SAMPLE_W-1:SAMPLE_W-4];
    end
  end

  jlpo_pwr_est #(
    .SAMPLE_W (SAMPLE_W)
  ) u_pwr_est (
    .clk_sys_in      (clk_sys_in),
    .rstn_in         (rstn_in),
    .enable_in       (power_estimate_enable_q),
    .sample_valid_in (sample_valid_in),
    .sample_in       (sample_in),
    .len_code_in     (power_average_length_q),
    .level_out       (pwr_level)
  );

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      detect_out <= 4'h0;
    end else begin
      case (det_src)
        jlpo_pkg::JLPO_DET_FAST:  detect_out <= fast_code_q;
        jlpo_pkg::JLPO_DET_POWER: detect_out <= pwr_level;
        default:                  detect_out <= 4'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_in)
      `JLPO_ADDR_LINK_CTRL: rd_mux = {7'h00, align_en_q};
      `JLPO_ADDR_GATES:     rd_mux = {6'h00, gate_k_q, gate_f_q};
      `JLPO_ADDR_SCRAMBLE:  rd_mux = {soft_scramble_enable_q, 7'h00};
      `JLPO_ADDR_OCTETS:    rd_mux = eff_octets;
      `JLPO_ADDR_FRAMES:    rd_mux = {3'h0, eff_frames};
      `JLPO_ADDR_DRIVER:    rd_mux = {4'h0, driver_current_code_q};
      `JLPO_ADDR_FORCE:     rd_mux = {1'b0, lane_two_force_q, 2'h0, lane_one_force_q, 3'h0};
      `JLPO_ADDR_L1_WORD_A: rd_mux = l1_word_a_q;
      `JLPO_ADDR_L1_WORD_B: rd_mux = {l1_word_b_q, 6'h00};
      `JLPO_ADDR_L2_WORD_A: rd_mux = {l2_word_a_q, 4'h0};
      `JLPO_ADDR_L2_WORD_B: rd_mux = {l2_word_b_q, 2'h0};
      `JLPO_ADDR_DETECT:    rd_mux = {2'h0, power_estimate_enable_q, power_average_length_q,
                                      1'b0, fast_code_detect_enable_q};
      default:              rd_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule // jlpo_regs

/* tb/jlpo_regs_chk.sv */
// Checker of the link parameter override register bank
`timescale 1ns/1ps

module jlpo_regs_chk (
  input wire logic       clk_sys_in,
  input wire logic       rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       scramble_pin_in,
  input wire logic [9:0] coder_lane1_in,
  input wire logic [7:0] octets_per_frame_out,
  input wire logic [4:0] frames_per_mf_out,
  input wire logic       scramble_enable_out,
  input wire logic [3:0] driver_current_code_out,
  input wire logic [5:0] driver_current_ma_out,
  input wire logic [9:0] lane1_out,
  input wire logic [9:0] lane2_out
);
  logic [7:0] gate_q, force_q, w6_q, w7_q, w8_q, w9_q;
  logic [9:0] l1_word, l2_word;
  assign l1_word = {w6_q, w7_q[7:6]};
  assign l2_word = {w8_q[7:4], w9_q[7:2]};
  // Shadow copies, so lane checks need no access to the bank's insides
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {gate_q, force_q, w6_q, w7_q, w8_q, w9_q} <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        8'hA1: gate_q <= reg_wdata_in;
        8'hB4: force_q <= reg_wdata_in;
        8'hB6: w6_q <= reg_wdata_in;
        8'hB7: w7_q <= reg_wdata_in;
        8'hB8: w8_q <= reg_wdata_in;
        8'hB9: w9_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  f_gate_open_a: assert property (reg_wr_in && reg_addr_in == 8'hA6 && gate_q[0]
    |-> ##2 octets_per_frame_out == $past(reg_wdata_in, 2)) else $error("F write lost");
  f_gate_shut_a: assert property (reg_wr_in && reg_addr_in == 8'hA6 && !gate_q[0]
    |=> ##1 $stable(octets_per_frame_out)) else $error("F write not gated");
  k_gate_open_a: assert property (reg_wr_in && reg_addr_in == 8'hA7 && gate_q[1]
    |-> ##2 frames_per_mf_out == $past(reg_wdata_in[4:0], 2)) else $error("K write lost");
  current_sum_a: assert property (driver_current_ma_out == 6'h10
    + 6'h10 * driver_current_code_out[3] - 6'h08 * driver_current_code_out[2]
    - 6'h04 * driver_current_code_out[1] - 6'h02 * driver_current_code_out[0])
    else $error("Current mismatch");
  scr_pin_a: assert property (scramble_pin_in |=> scramble_enable_out)
    else $error("Pin scramble off");
  lane1_force_a: assert property (force_q[3] |=> lane1_out == $past(l1_word))
    else $error("Lane one word");
  lane1_pass_a: assert property (!force_q[3] |=> lane1_out == $past(coder_lane1_in))
    else $error("Lane one coder");
  lane2_force_a: assert property (force_q[6] |=> lane2_out == $past(l2_word))
    else $error("Lane two word");
endmodule // jlpo_regs_chk

bind jlpo_regs jlpo_regs_chk i_chk (.*);

/* tb/jlpo_rx_model.sv */
// Receiver model that requests sync and releases it after a delay
`timescale 1ns/1ps

module jlpo_rx_model #(
  parameter int SYNC_DLY = 8
) (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic resync_in,
  output logic      sync_req_n_out
);
  int cnt_q;
  // Larger SYNC_DLY mimics a slow receiver lock
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 0;
      sync_req_n_out <= 1'b0;
    end else if (resync_in) begin
      cnt_q <= 0;
      sync_req_n_out <= 1'b0;
    end else if (cnt_q < SYNC_DLY) begin
      cnt_q <= cnt_q + 1;
    end else begin
      sync_req_n_out <= 1'b1;
    end
  end
endmodule // jlpo_rx_model

/* tb/tb.sv */
// Self-checking bench of the link parameter override register bank
`timescale 1ns/1ps

module tb;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, resync = 1'b1;
  logic scramble_pin_in = 1'b0, frame_tick_in = 1'b0, sample_valid_in = 1'b0, sync_req_n_in;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, rd_q, f;
  logic [7:0] octets_per_frame_out, b [4];
  logic [9:0] coder_lane1_in = 10'h000, coder_lane2_in = 10'h000, lane1_out, lane2_out;
  logic [13:0] sample_in = 14'h0000;
  logic [4:0] frames_per_mf_out;
  logic [5:0] driver_current_ma_out;
  logic [3:0] driver_current_code_out, detect_out;
  logic [1:0] link_phase_out;
  logic dual_lane_out, scramble_enable_out, ilas_active_out;
  int num_errors = 0, check_count = 0, seed = 32'h184e;

  always #10 clk_sys_in = ~clk_sys_in;
  jlpo_regs i_dut (.*);
  jlpo_rx_model i_rx (.clk_sys_in, .rstn_in, .resync_in(resync), .sync_req_n_out(sync_req_n_in));
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 rd_q = reg_rdata_out;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic tick;
    @(posedge clk_sys_in);
    frame_tick_in <= 1'b1;
    @(posedge clk_sys_in);
    frame_tick_in <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [9:0] exp_ma(input logic [3:0] c);
    return 10'(16 + 16 * c[3] - 8 * c[2] - 4 * c[1] - 2 * c[0]);
  endfunction
  task automatic end_sim;
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(8'hA6);
    chk("f_reset", 10'h001, rd_q);
    rd(8'hA7);
    chk("k_reset", 10'h008, rd_q);
    wr(8'hA6, 8'h00);
    rd(8'hA6);
    chk("f_locked", 10'h001, rd_q);
    wr(8'hA1, 8'h01);
    wr(8'hA6, 8'h00);
    wr(8'hA7, 8'h16);
    rd(8'hA7);
    chk("k_10x", 10'h010, rd_q);
    chk("dual", 10'h001, dual_lane_out);
    wr(8'hA1, 8'h03);
    wr(8'hA7, 8'h16);
    rd(8'hA7);
    chk("k_set", 10'h016, rd_q);
    wr(8'h55, 8'hFF);
    rd(8'h55);
    chk("unmapped", 10'h000, rd_q);
    for (int c = 0; c < 16; c++) begin
      wr(8'hB0, 8'(c));
      rd(8'hB0);
      chk("ma", exp_ma(4'(c)), driver_current_ma_out);
      chk("code", 10'(c), rd_q);
      chk("code_out", 10'(c), driver_current_code_out);
    end
    for (int s = 0; s < 4; s++) begin
      scramble_pin_in <= s[0];
      wr(8'hA5, {s[1], 7'h00});
      rd(8'hA5);
      chk("scr", 10'(s[0] | s[1]), scramble_enable_out);
    end
    for (int i = 0; i < 12; i++) begin
      foreach (b[j]) b[j] = 8'($random(seed));
      f = i == 0 ? 8'h48 : (i == 1 ? 8'h00 : 8'($random(seed)));
      coder_lane1_in <= 10'($random(seed));
      coder_lane2_in <= 10'($random(seed));
      for (int j = 0; j < 4; j++) wr(8'hB6 + 8'(j), b[j]);
      wr(8'hB4, f);
      wt(3);
      chk("lane1", f[3] ? {b[0], b[1][7:6]} : coder_lane1_in, lane1_out);
      chk("lane2", f[6] ? {b[2][7:4], b[3][7:2]} : coder_lane2_in, lane2_out);
    end
    sample_in <= 14'($random(seed));
    sample_valid_in <= 1'b1;
    wr(8'hD6, 8'h21);
    wt(4);
    chk("det_fast", 10'(sample_in[13:10]), detect_out);
    wr(8'hD6, 8'h3D);
    rd(8'hD6);
    chk("det_reg", 10'h03D, rd_q);
    // Full-scale constant input, two blocks of 1K so one is clean
    sample_in <= 14'h1FFF;
    wr(8'hD6, 8'h20);
    wt(2100);
    chk("det_pwr", 10'h00F, detect_out);
    wr(8'hD6, 8'h00);
    wt(3);
    chk("det_off", 10'h000, detect_out);
    wr(8'hA0, 8'h01);
    resync <= 1'b0;
    wt(12);
    chk("ilas", 10'h001, link_phase_out);
    chk("ilas_flag", 10'h001, ilas_active_out);
    repeat (4 * 23 - 1) tick;
    wt(2);
    chk("ilas_hold", 10'h001, link_phase_out);
    tick;
    wt(2);
    chk("data", 10'h002, link_phase_out);
    chk("ilas_done", 10'h000, ilas_active_out);
    resync <= 1'b1;
    wt(3);
    chk("cgs", 10'h000, link_phase_out);
    wr(8'hA0, 8'h00);
    resync <= 1'b0;
    wt(12);
    chk("no_ilas", 10'h002, link_phase_out);
    end_sim;
  end
  // Whole run needs about 2600 cycles
  initial begin
    #(20 * 20000);
    num_errors++;
    end_sim;
  end
endmodule // tb
